// file: hdl/iprc_defines.svh
// Offsets, field positions, reset values and counts of the priority controller
`ifndef IPRC_DEFINES_SVH
`define IPRC_DEFINES_SVH

// ----------------------------------------------------------------
// Device register indices (word registers, 7-bit local address)
// ----------------------------------------------------------------
`define IPRC_REG_FLAG 7'h00
`define IPRC_REG_ENABLE 7'h01
`define IPRC_REG_PRIO14 7'h02
`define IPRC_REG_PRIO15 7'h03
`define IPRC_REG_PRIO16 7'h04
`define IPRC_REG_PRIO17 7'h05
`define IPRC_REG_STATUS 7'h06
`define IPRC_REG_CTRL1 7'h07

// ----------------------------------------------------------------
// Device field positions and reset values
// ----------------------------------------------------------------
`define IPRC_NUM_SRC 8
`define IPRC_NUM_TRAP 4
`define IPRC_PRIO_RESET 3'h4
`define IPRC_PRIO_TOP 3'h7
`define IPRC_PRIO_OFF 3'h0
`define IPRC_STAT_LVL_POS 8
`define IPRC_NEST_DIS_POS 15
`define IPRC_TRAP_LVL_BASE 4'h8
`define IPRC_USER_VEC_BASE 7'h04

// ----------------------------------------------------------------
// Controller register indices (8-bit software address)
// ----------------------------------------------------------------
`define IPRC_H_SLB 8'h00
`define IPRC_H_CMD 8'h01
`define IPRC_H_DISABLE 8'h02
`define IPRC_H_PC 8'h03
`define IPRC_H_STAT 8'h04
`define IPRC_H_MASK 8'h05
`define IPRC_H_TAKEN 8'h06
`define IPRC_H_DEPTH 8'h07
`define IPRC_H_DEV_BIT 7

// ----------------------------------------------------------------
// Controller fields
// ----------------------------------------------------------------
`define IPRC_STACK_DEPTH 3'h4
`define IPRC_CMD_RETURN_POS 0
`define IPRC_EV_TAKEN 0
`define IPRC_EV_RETURN 1
`define IPRC_EV_REFUSED 2
`define IPRC_SLB_LVL_LSB 1

`endif

// file: hdl/iprc_pkg.sv
// Types shared by both ends of the priority controller
package iprc_pkg;

  typedef logic [2:0] iprc_prio_t;

  // Device state
  typedef struct packed {
    logic [7:0] flag;
    logic [7:0] enable;
    iprc_prio_t [7:0] prio;
    logic nest_dis;
    logic [3:0] trap_flag;
    logic irq;
    logic [3:0] lvl;
    logic [6:0] vec;
    logic [15:0] rdata;
  } iprc_dev_state_t;

  // One saved context
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] slb;
    logic [3:0] level;
  } iprc_frame_t;

  // Controller state
  typedef struct packed {
    iprc_frame_t [3:0] stack;
    logic [2:0] depth;
    logic [15:0] pc;
    logic [7:0] slb;
    logic [3:0] level;
    logic [15:0] dis_cnt;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [15:0] rdata;
    logic fwd_rd;
    logic ack;
    logic [6:0] taken_vec;
    logic [3:0] taken_lvl;
  } iprc_cpu_state_t;

endpackage

// file: hdl/iprc_link_if.sv
// Link between the priority controller and the processor-side end
`timescale 1ns/100ps
interface iprc_link_if;
  logic [6:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic irq_req;
  logic [3:0] irq_level;
  logic [6:0] irq_vector;
  logic [3:0] cpu_level;
  logic in_service;
  logic dis_active;
  logic take;

  modport dev (
    input reg_addr, reg_wdata, reg_wr, reg_rd, cpu_level, in_service, dis_active, take,
    output reg_rdata, irq_req, irq_level, irq_vector
  );

  modport cpu (
    output reg_addr, reg_wdata, reg_wr, reg_rd, cpu_level, in_service, dis_active, take,
    input reg_rdata, irq_req, irq_level, irq_vector
  );
endinterface

// file: hdl/iprc_dev.sv
// Interrupt priority controller: flags, enables, priorities, arbitration
//
// Function
// - Three-bit priority, 7 highest, 0 disables source
// - Reset loads every user priority with 4
// - Unimplemented bits read zero, writes ignored
// - Status bits 11:8 give new CPU level
// - Status bits 6:0 give vector minus eight
// - Set flag keeps requesting; handler clears it
// - Return pops PC, status byte, old level
// - Trap flag stays active until cleared
// - Nesting disable blocks preemption of running handler by user sources; traps still preempt
// - CPU level 7 blocks all user sources
// - Traps use levels 8-11, never masked
// - Timed disable masks levels 1-6, not 7
// - Request needs enable, flag and nonzero priority
// - Software sets priority, clears flag, then enables
// - Software may use one common nonzero priority
`timescale 1ns/100ps
`include "iprc_defines.svh"
module iprc_dev (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Link to the processor end
  iprc_link_if.dev link,
  // Peripheral and trap events
  input wire logic [7:0] src_event,
  input wire logic [3:0] trap_event,
  // Observation
  output logic [7:0] flag_out,
  output logic [3:0] trap_flag_out
);

  // ----------------------------------------------------------------
  // Field map of the priority registers
  // ----------------------------------------------------------------

  // Register that holds the field of source i
  function automatic logic [6:0] src_reg(input int i);
    case (i)
      0: src_reg = `IPRC_REG_PRIO14;
      1: src_reg = `IPRC_REG_PRIO15;
      2: src_reg = `IPRC_REG_PRIO16;
      3: src_reg = `IPRC_REG_PRIO16;
      default: src_reg = `IPRC_REG_PRIO17;
    endcase
  endfunction

  // Low bit of the field of source i inside its register
  function automatic int src_pos(input int i);
    case (i)
      0: src_pos = 0;
      1: src_pos = 4;
      2: src_pos = 4;
      3: src_pos = 8;
      4: src_pos = 0;
      5: src_pos = 4;
      6: src_pos = 8;
      default: src_pos = 12;
    endcase
  endfunction

  // Vector code of user source i, traps take the codes below
  function automatic logic [6:0] user_vec(input int i);
    user_vec = `IPRC_USER_VEC_BASE + 7'(i);
  endfunction

  iprc_pkg::iprc_dev_state_t st_reg;
  iprc_pkg::iprc_dev_state_t st_next;

  logic [3:0] best_lvl;
  logic [6:0] best_vec;
  logic best_found;
  logic user_block;
  logic [3:0] tlvl;
  logic [15:0] rd_word;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------

  // Strict compare in ascending vector order keeps the lowest vector on a tie,
  // and seeding with the CPU level means only a higher level can win
  always_comb begin
    best_lvl = link.cpu_level;
    best_vec = 7'h00;
    best_found = 1'b0;
    tlvl = 4'h0;
    // Nesting disable holds off user sources while a handler runs
    user_block = st_reg.nest_dis && link.in_service;
    for (int t = 0; t < `IPRC_NUM_TRAP; t++) begin
      tlvl = `IPRC_TRAP_LVL_BASE + 4'(t);
      if (st_reg.trap_flag[t] && (tlvl > best_lvl)) begin
        best_lvl = tlvl;
        best_vec = 7'(t);
        best_found = 1'b1;
      end
    end
    for (int i = 0; i < `IPRC_NUM_SRC; i++) begin
      // User levels top out at 7, so a CPU level of 7 stops them all
      if (st_reg.flag[i] && st_reg.enable[i] && (st_reg.prio[i] != `IPRC_PRIO_OFF)
          && !user_block
          && !(link.dis_active && (st_reg.prio[i] != `IPRC_PRIO_TOP))
          && ({1'b0, st_reg.prio[i]} > best_lvl)) begin
        best_lvl = {1'b0, st_reg.prio[i]};
        best_vec = user_vec(i);
        best_found = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read word
  // ----------------------------------------------------------------

  // Bits not listed here stay zero
  always_comb begin
    rd_word = 16'h0000;
    case (link.reg_addr)
      `IPRC_REG_FLAG: rd_word[7:0] = st_reg.flag;
      `IPRC_REG_ENABLE: rd_word[7:0] = st_reg.enable;
      `IPRC_REG_STATUS: begin
        rd_word[11:8] = st_reg.lvl;
        rd_word[6:0] = st_reg.vec;
      end
      `IPRC_REG_CTRL1: begin
        rd_word[`IPRC_NEST_DIS_POS] = st_reg.nest_dis;
        rd_word[3:0] = st_reg.trap_flag;
      end
      default: begin
        for (int i = 0; i < `IPRC_NUM_SRC; i++) begin
          if (src_reg(i) == link.reg_addr) begin
            rd_word[src_pos(i) +: 3] = st_reg.prio[i];
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Hardware events are applied after the write, so a set beats a clear
  always_comb begin
    st_next = st_reg;
    if (link.reg_wr) begin
      case (link.reg_addr)
        `IPRC_REG_FLAG: st_next.flag = link.reg_wdata[7:0];
        `IPRC_REG_ENABLE: st_next.enable = link.reg_wdata[7:0];
        `IPRC_REG_CTRL1: begin
          st_next.nest_dis = link.reg_wdata[`IPRC_NEST_DIS_POS];
          st_next.trap_flag = link.reg_wdata[3:0];
        end
        default: begin
          for (int i = 0; i < `IPRC_NUM_SRC; i++) begin
            if (src_reg(i) == link.reg_addr) begin
              st_next.prio[i] = link.reg_wdata[src_pos(i) +: 3];
            end
          end
        end
      endcase
    end
    // A flag that stays set keeps the source requesting
    st_next.flag = st_next.flag | src_event;
    st_next.trap_flag = st_next.trap_flag | trap_event;
    st_next.irq = best_found;
    st_next.lvl = best_found ? best_lvl : 4'h0;
    st_next.vec = best_vec;
    // Read data stands in the cycle after the strobe
    st_next.rdata = link.reg_rd ? rd_word : 16'h0000;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Clock enable low freezes everything
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      for (int i = 0; i < `IPRC_NUM_SRC; i++) begin
        st_reg.prio[i] <= `IPRC_PRIO_RESET;
      end
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Request, level and vector all come from flops
  assign link.reg_rdata = st_reg.rdata;
  assign link.irq_req = st_reg.irq;
  assign link.irq_level = st_reg.lvl;
  assign link.irq_vector = st_reg.vec;
  assign flag_out = st_reg.flag;
  assign trap_flag_out = st_reg.trap_flag;

  // The take strobe is left unread on purpose: hardware never clears a flag,
  // so a handler that forgets to clear its flag is entered again at once

endmodule

// file: hdl/iprc_cpu.sv
// Processor-side end: takes requests, stacks context, returns, timed disable
`timescale 1ns/100ps
`include "iprc_defines.svh"
module iprc_cpu (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Link to the priority controller
  iprc_link_if.cpu link,
  // Software register port
  input wire logic [7:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // Interrupt to software
  output logic host_irq
);

  iprc_pkg::iprc_cpu_state_t st_reg;
  iprc_pkg::iprc_cpu_state_t st_next;

  logic to_dev;
  logic local_wr;
  logic do_return;
  logic pop_ok;
  logic do_take;
  logic want_take;
  logic [15:0] rd_word;
  logic [2:0] ev;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  // Upper half of the address space is passed through to the controller
  assign to_dev = sw_addr[`IPRC_H_DEV_BIT];
  assign local_wr = sw_wr && !to_dev;
  assign do_return = local_wr && (sw_addr == `IPRC_H_CMD) && sw_wdata[`IPRC_CMD_RETURN_POS];
  // Own level compare guards against a request still showing the old level
  assign want_take = link.irq_req && (link.irq_level > st_reg.level);
  // A return that pops goes first and the take follows a cycle later;
  // a refused return on an empty stack must not hold a request off
  assign pop_ok = do_return && (st_reg.depth != 3'h0);
  assign do_take = want_take && !pop_ok && (st_reg.depth < `IPRC_STACK_DEPTH);

  // ----------------------------------------------------------------
  // Read word
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 16'h0000;
    case (sw_addr)
      `IPRC_H_SLB: rd_word[7:0] = st_reg.slb;
      `IPRC_H_DISABLE: rd_word = st_reg.dis_cnt;
      `IPRC_H_PC: rd_word = st_reg.pc;
      `IPRC_H_STAT: rd_word[2:0] = st_reg.stat;
      `IPRC_H_MASK: rd_word[2:0] = st_reg.mask;
      `IPRC_H_TAKEN: rd_word = {4'h0, st_reg.taken_lvl, 1'b0, st_reg.taken_vec};
      `IPRC_H_DEPTH: rd_word = {9'h000, st_reg.level, st_reg.depth};
      default: rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    ev = 3'h0;
    st_next.ack = 1'b0;
    if (local_wr) begin
      case (sw_addr)
        `IPRC_H_SLB: begin
          st_next.slb = sw_wdata[7:0];
          // Or-ing 0x0E raises the level to 7 and holds off all user sources
          st_next.level = {1'b0, sw_wdata[`IPRC_SLB_LVL_LSB +: 3]};
        end
        `IPRC_H_DISABLE: st_next.dis_cnt = sw_wdata;
        `IPRC_H_PC: st_next.pc = sw_wdata;
        `IPRC_H_MASK: st_next.mask = sw_wdata[2:0];
        default: st_next.dis_cnt = st_reg.dis_cnt;
      endcase
    end else if (st_reg.dis_cnt != 16'h0000) begin
      st_next.dis_cnt = st_reg.dis_cnt - 16'h0001;
    end
    if (do_return && !pop_ok) begin
      ev[`IPRC_EV_REFUSED] = 1'b1;
    end
    if (pop_ok) begin
      // Restore the context saved at entry
      st_next.pc = st_reg.stack[st_reg.depth[1:0] - 2'h1].pc;
      st_next.slb = st_reg.stack[st_reg.depth[1:0] - 2'h1].slb;
      st_next.level = st_reg.stack[st_reg.depth[1:0] - 2'h1].level;
      st_next.depth = st_reg.depth - 3'h1;
      ev[`IPRC_EV_RETURN] = 1'b1;
    end else if (do_take) begin
      st_next.stack[st_reg.depth[1:0]] = {st_reg.pc, st_reg.slb, st_reg.level};
      st_next.depth = st_reg.depth + 3'h1;
      st_next.level = link.irq_level;
      st_next.slb[`IPRC_SLB_LVL_LSB +: 3] = link.irq_level[2:0];
      st_next.pc = {9'h000, link.irq_vector};
      st_next.taken_vec = link.irq_vector;
      st_next.taken_lvl = link.irq_level;
      st_next.ack = 1'b1;
      ev[`IPRC_EV_TAKEN] = 1'b1;
    end else if (want_take) begin
      ev[`IPRC_EV_REFUSED] = 1'b1;
    end
    // Read clears, a new event in the same cycle still sets
    if (sw_rd && (sw_addr == `IPRC_H_STAT)) begin
      st_next.stat = ev;
    end else begin
      st_next.stat = st_reg.stat | ev;
    end
    st_next.fwd_rd = sw_rd && to_dev;
    st_next.rdata = (sw_rd && !to_dev) ? rd_word : 16'h0000;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Pass-through strobes are combinational so the controller answers in one cycle
  assign link.reg_addr = sw_addr[6:0];
  assign link.reg_wdata = sw_wdata;
  assign link.reg_wr = sw_wr && to_dev;
  assign link.reg_rd = sw_rd && to_dev;
  assign link.cpu_level = st_reg.level;
  assign link.in_service = st_reg.depth != 3'h0;
  assign link.dis_active = st_reg.dis_cnt != 16'h0000;
  assign link.take = st_reg.ack;
  assign sw_rdata = st_reg.fwd_rd ? link.reg_rdata : st_reg.rdata;
  assign host_irq = |(st_reg.stat & st_reg.mask);

endmodule

// file: tb/iprc_assertions.sv
// Link checks between the priority controller and the processor end
`timescale 1ns/100ps
module iprc_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register path
  input wire logic [6:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Request and grant path
  input wire logic irq_req,
  input wire logic [3:0] irq_level,
  input wire logic [6:0] irq_vector,
  input wire logic [3:0] cpu_level,
  input wire logic in_service,
  input wire logic dis_active,
  input wire logic take
);
  // ------------------------------------------------------------
  // One clock domain, so clock and reset are given once
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Grant needs an empty stack, so a pending return cannot steal the cycle
  sequence s_grant;
    irq_req && (irq_level > cpu_level) && !in_service && !dis_active;
  endsequence
  sequence s_taken;
    take && in_service;
  endsequence

  // Register path and request relations
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_status_spare_zero: assert property (reg_rd && reg_addr == 7'h06 |=>
    reg_rdata[15:12] == 4'h0 && !reg_rdata[7])
    else $error("status spare bits not zero");
  a_prio14_spare_zero: assert property (reg_rd && reg_addr == 7'h02 |=>
    reg_rdata[15:3] == 13'h0000)
    else $error("priority 14 spare bits not zero");
  a_user_above_cpu: assert property (irq_req && !irq_level[3] |->
    irq_level > $past(cpu_level))
    else $error("user request not above cpu level");
  a_trap_code_map: assert property (irq_req && irq_level[3] |->
    irq_vector == {4'h0, irq_level[2:0]})
    else $error("trap level and code disagree");
  a_level_nonzero: assert property (irq_req |-> irq_level != 4'h0 && irq_vector <= 7'h0B)
    else $error("request with level zero or bad code");
  a_dis_top_only: assert property (irq_req && !irq_level[3] && $past(dis_active) |->
    irq_level == 4'h7)
    else $error("timed disable let a low level through");
  a_grant_taken: assert property (s_grant |=> s_taken)
    else $error("winning request not taken");
  a_take_level: assert property (take |-> cpu_level == $past(irq_level))
    else $error("cpu level not the taken level");
endmodule

// file: tb/interrupt_priority_control_tb.sv
// Self-checking bench joining both ends of the priority controller
`timescale 1ns/100ps
module interrupt_priority_control_tb;
  // Stimulus and observed outputs
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] sw_addr = 8'h00;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] src_event = 8'h00;
  logic [3:0] trap_event = 4'h0;
  logic [15:0] sw_rdata;
  logic host_irq;
  logic [7:0] flag_out;
  logic [3:0] trap_flag_out;
  int n_fail = 0;
  int samples_checked = 0;
  typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] q;} iprc_row_t;
  // Write, expected read-back; wide writes show which bits exist
  iprc_row_t rows [9] = '{'{8'h82, 16'hFFFF, 16'h0007}, '{8'h83, 16'hFFFF, 16'h0070},
    '{8'h84, 16'hFFFF, 16'h0770}, '{8'h85, 16'hFFFF, 16'h7777}, '{8'h86, 16'hFFFF, 16'h0000},
    '{8'h87, 16'h8000, 16'h8000}, '{8'h8A, 16'hFFFF, 16'h0000}, '{8'h05, 16'hFFFF, 16'h0007},
    '{8'h0A, 16'hFFFF, 16'h0000}};

  // ------------------------------------------------------------
  // Both ends, the link and its checker
  // ------------------------------------------------------------
  iprc_link_if link ();
  iprc_dev u_iprc_dev (.core_clk(core_clk), .rstn(rstn), .ce(ce), .link(link),
    .src_event(src_event), .trap_event(trap_event), .flag_out(flag_out),
    .trap_flag_out(trap_flag_out));
  iprc_cpu u_iprc_cpu (.core_clk(core_clk), .rstn(rstn), .ce(ce), .link(link),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .host_irq(host_irq));
  iprc_assertions u_iprc_assertions (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(link.reg_addr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata),
    .irq_req(link.irq_req), .irq_level(link.irq_level), .irq_vector(link.irq_vector),
    .cpu_level(link.cpu_level), .in_service(link.in_service),
    .dis_active(link.dis_active), .take(link.take));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1;
    chk($sformatf("read %h", a), exp, sw_rdata);
  endtask
  // Events last one cycle; six cycles cover flag, request and take
  task automatic pulse(input logic [7:0] s, input logic [3:0] t);
    @(posedge core_clk);
    src_event <= s;
    trap_event <= t;
    @(posedge core_clk);
    src_event <= 8'h00;
    trap_event <= 4'h0;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Clock and watchdog; the tests need well under a thousand cycles
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #40000;
    n_fail++;
    $display("watchdog expired");
    end_sim();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q);
    end
    $display("register table done");
    // Second reset in mid-run brings every priority back to four
    do_reset();
    rd(8'h82, 16'h0004);
    rd(8'h83, 16'h0040);
    rd(8'h84, 16'h0440);
    rd(8'h85, 16'h4444);
    rd(8'h87, 16'h0000);
    // A return with nothing stacked is refused and flagged
    wr(8'h01, 16'h0001);
    rd(8'h04, 16'h0004);
    $display("reset test done");
    // Flag without enable stays silent, then enable lets it in
    wr(8'h05, 16'h0001);
    wr(8'h03, 16'h1234);
    pulse(8'h02, 4'h0);
    chk("flag", 16'h0002, {8'h00, flag_out});
    rd(8'h04, 16'h0000);
    wr(8'h81, 16'h0002);
    repeat (6) @(posedge core_clk);
    chk("host_irq", 16'h0001, {15'h0000, host_irq});
    rd(8'h06, 16'h0405);
    rd(8'h03, 16'h0005);
    rd(8'h04, 16'h0001);
    rd(8'h04, 16'h0000);
    chk("host_irq", 16'h0000, {15'h0000, host_irq});
    // Return with the flag still set re-enters at once
    wr(8'h01, 16'h0001);
    repeat (6) @(posedge core_clk);
    rd(8'h04, 16'h0003);
    rd(8'h07, 16'h0021);
    wr(8'h80, 16'h0000);
    wr(8'h01, 16'h0001);
    repeat (6) @(posedge core_clk);
    rd(8'h07, 16'h0000);
    rd(8'h03, 16'h1234);
    $display("nesting and return test done");
    // Level seven blocks users; a trap still gets through and stays flagged
    wr(8'h00, 16'h000E);
    pulse(8'h02, 4'h0);
    // Only the earlier return is flagged; nothing is taken at level seven
    rd(8'h04, 16'h0002);
    pulse(8'h00, 4'h1);
    rd(8'h06, 16'h0800);
    chk("trap flag", 16'h0001, {12'h000, trap_flag_out});
    wr(8'h87, 16'h0000);
    #1;
    chk("trap flag", 16'h0000, {12'h000, trap_flag_out});
    wr(8'h01, 16'h0001);
    repeat (6) @(posedge core_clk);
    rd(8'h07, 16'h0038);
    rd(8'h00, 16'h000E);
    $display("level seven and trap test done");
    // Timed disable: level seven wins, level six waits for the count
    wr(8'h84, 16'h0760);
    wr(8'h80, 16'h0000);
    wr(8'h81, 16'h000C);
    wr(8'h00, 16'h0000);
    wr(8'h02, 16'h0064);
    pulse(8'h0C, 4'h0);
    rd(8'h06, 16'h0707);
    // The trap handler's return is still flagged beside the new take
    rd(8'h04, 16'h0003);
    wr(8'h80, 16'h0004);
    wr(8'h01, 16'h0001);
    repeat (6) @(posedge core_clk);
    rd(8'h04, 16'h0002);
    repeat (100) @(posedge core_clk);
    rd(8'h06, 16'h0606);
    rd(8'h04, 16'h0001);
    // Nesting disable keeps level seven out of a running handler
    wr(8'h87, 16'h8000);
    pulse(8'h08, 4'h0);
    rd(8'h04, 16'h0000);
    $display("timed disable and nesting test done");
    // Clock enable low freezes both ends, so this write is lost
    @(posedge core_clk);
    ce <= 1'b0;
    wr(8'h02, 16'h0005);
    ce <= 1'b1;
    rd(8'h02, 16'h0000);
    $display("clock enable test done");
    // Every source at the common reset level: the lower vector wins the tie,
    // and the status register shows it in the cycle before the take
    do_reset();
    wr(8'h80, 16'h0000);
    wr(8'h81, 16'h0030);
    @(posedge core_clk);
    src_event <= 8'h30;
    @(posedge core_clk);
    src_event <= 8'h00;
    rd(8'h86, 16'h0408);
    rd(8'h06, 16'h0408);
    $display("tie and status test done");
    end_sim();
  end
endmodule
